// ==== rtl/ecwl_loader.sv ====
`timescale 1ns/100ps
`include "ecwl_consts.svh"

// Functional notes
// [RL1] Control bit 5 enables link-change wakeup.
// [RL2] Control bit 7 selects LED mode.
// [RL3] Control bit 8 powers internal PHY.
// [RL4] Control bit 9 selects fiber mode.
// [RL5] Control bit 11 copied to register 0Fh bit 7.
// [RL6] Control bit 14 enables automatic crossover.
// [RL7] EEPROM bits 12, 13, 15 must be zero.
// [RL8] Word 8 low byte: vendor string address.
// [RL9] Word 8 high byte: vendor string length.
// [RL10] Word 9 low byte: product string address.
// [RL11] Word 9 high byte: product string length.
// [RL12] Control bit 4 enables magic packet wakeup.
// [RL13] Load once after reset before settings apply.
module ecwl_loader
    import ecwl_pkg::*;
(
    input  wire logic          ref_clk_in,
    input  wire logic          rst_n_in,
    output ecwl_ee_req_t       ee_req_out,
    input  wire logic          ee_ack_in,
    input  wire logic [15:0]   ee_data_in,
    input  ecwl_reg_req_t      reg_req_in,
    output logic      [7:0]    reg_rdata_out,
    output ecwl_cfg_t          cfg_out,
    output ecwl_str_t          str_out,
    output logic               load_done_out
);

    // Whole state of the loader in one record.
    // The fsm field walks request and wait for each word, then commit and done once per load.
    // The word index names the EEPROM word in flight and the image slot it fills.
    // The ee field is the registered request seen by the EEPROM access engine.
    // Both stage fields collect the words while a load is running.
    // The cfg and str fields are the settings in force; a commit moves them, and a wake control write also moves the management event enable.
    // The done flag rises at the first commit and stays high through reloads.
    // The rsv_err flag tells whether the last commit saw reserved bits set.
    // Image index and word give software a look at any word of the image.
    // The rdata field is the read data register, zero outside a read answer.
    typedef struct packed {
        ecwl_fsm_t    fsm;
        logic [7:0]   word_idx;
        ecwl_ee_req_t ee;
        logic [15:0]  ctrl_stage;
        ecwl_str_t    str_stage;
        ecwl_cfg_t    cfg;
        ecwl_str_t    str;
        logic         done;
        logic         rsv_err;
        logic [3:0]   img_index;
        logic [15:0]  img_word;
        logic [7:0]   rdata;
    } ecwl_loader_state_t;

    // Registered state and its next value; the store's read data sit beside them.
    ecwl_loader_state_t st;
    ecwl_loader_state_t next_st;
    logic               mem_we;
    logic [15:0]        mem_rdata;

    // Decode of the register port, used by both the write and read paths.
    // Keeping it in one place means both paths always agree on an offset.
    function automatic logic hit(input ecwl_reg_req_t r, input logic [7:0] offset);
        hit = (r.addr == offset);
    endfunction : hit

    // Packs the decoded settings into one byte for software.
    // The top bit reads zero, which leaves room for one more setting.
    function automatic logic [7:0] cfg_byte(input ecwl_cfg_t c);
        cfg_byte = {1'b0, c};
    endfunction : cfg_byte

    // Every accepted word is mirrored into the image store.
    // The store is written on the edge that fills the staging field, so both agree.
    assign mem_we = (st.fsm == ECWL_WAIT) && ee_ack_in;

    // Only word indices 7 to 9 are ever fetched, so most of the sixteen slots
    // stay unused; the spare room keeps the index a plain nibble.
    ecwl_img_mem u_img_mem (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .we_in      (mem_we),
        .waddr_in   (st.word_idx[3:0]),
        .wdata_in   (ee_data_in),
        .raddr_in   (st.img_index),
        .rdata_out  (mem_rdata)
    );

    // Timing of one word, in rising edges of the clock.
    // The edge that leaves ECWL_REQ raises the request beside the word index.
    // Request and index then hold for as many edges as the EEPROM needs.
    // The edge that samples the answer drops the request and stores the word.
    // The edge after that raises the request again for the next index.
    // After the last word one more edge commits, and all settings move there.
    // A whole load is three word times and one commit cycle.
    // An answer that arrives while no request stands is ignored, since only
    // ECWL_WAIT looks at it; a misbehaving engine cannot inject a word.

    // Next-state logic: load sequence, commit, and the register port.
    always_comb
    begin
        next_st          = st;
        next_st.rdata    = 8'h00;
        next_st.img_word = mem_rdata;

        unique case (st.fsm)
            // Issue one word request; the request holds until the word arrives.
            // The index is copied here rather than in the wait state, so the
            // address is settled before the EEPROM may answer.
            ECWL_REQ:
            begin
                next_st.ee.req  = 1'b1;
                next_st.ee.addr = st.word_idx;
                next_st.fsm     = ECWL_WAIT;
            end

            // Sort each returned word into its staging field.
            // Indices other than the three known words only land in the store.
            ECWL_WAIT:
            begin
                if (ee_ack_in)
                begin
                    next_st.ee.req = 1'b0;
                    if (st.word_idx == `ECWL_WORD_CTRL)
                    begin
                        next_st.ctrl_stage = ee_data_in;
                    end
                    if (st.word_idx == `ECWL_WORD_STR1)
                    begin
                        next_st.str_stage.vendor_addr = ee_data_in[7:0];   // RL8
                        next_st.str_stage.vendor_len  = ee_data_in[15:8];  // RL9
                    end
                    if (st.word_idx == `ECWL_WORD_STR2)
                    begin
                        next_st.str_stage.product_addr = ee_data_in[7:0];  // RL10
                        next_st.str_stage.product_len  = ee_data_in[15:8]; // RL11
                    end
                    if (st.word_idx == `ECWL_WORD_STR2)
                    begin
                        next_st.fsm = ECWL_COMMIT;
                    end
                    else
                    begin
                        next_st.word_idx = st.word_idx + 8'h01;
                        next_st.fsm      = ECWL_REQ;
                    end
                end
            end

            // All words are in; the settings change together in one cycle so
            // the PHY and LED logic never see a half-loaded mix.
            ECWL_COMMIT:
            begin
                // Each setting takes its own bit straight from the staged word.
                next_st.cfg.wake_magic_en = st.ctrl_stage[`ECWL_BIT_MAGIC];  // RL12
                next_st.cfg.wake_link_en  = st.ctrl_stage[`ECWL_BIT_LINK];   // RL1
                next_st.cfg.led_mode      = st.ctrl_stage[`ECWL_BIT_LED];    // RL2
                next_st.cfg.phy_enable    = st.ctrl_stage[`ECWL_BIT_PHY];    // RL3
                next_st.cfg.fiber_mode    = st.ctrl_stage[`ECWL_BIT_FIBER];  // RL4
                next_st.cfg.wake_lan_mgmt_event =
                    st.ctrl_stage[`ECWL_BIT_WLME];                           // RL5
                next_st.cfg.mdix_en       = st.ctrl_stage[`ECWL_BIT_MDIX];   // RL6
                next_st.str               = st.str_stage;
                // A badly programmed part is flagged, not refused.
                // Loading it anyway keeps a board usable; software reads the flag.
                next_st.rsv_err = st.ctrl_stage[`ECWL_BIT_RSV12] |
                                  st.ctrl_stage[`ECWL_BIT_RSV13] |
                                  st.ctrl_stage[`ECWL_BIT_RSV15];            // RL7
                next_st.done    = 1'b1;                                      // RL13
                next_st.fsm     = ECWL_DONE;
            end

            // Idle until software asks for a fresh load.
            // A reload keeps the present settings until its own commit.
            // A reload write while busy is not decoded, so it cannot restart a load.
            ECWL_DONE:
            begin
                if (reg_req_in.wr && hit(reg_req_in, `ECWL_REG_LOAD_CTRL) &&
                    reg_req_in.wdata[`ECWL_CTRL_RELOAD])
                begin
                    next_st.word_idx = `ECWL_WORD_CTRL;
                    next_st.fsm      = ECWL_REQ;
                end
            end
        endcase

        // Register map, all eight bits wide.
        // Offset 0Fh is wake control: bit 7 is the management event enable.
        // Offset 20h is load status: bit 0 done, bit 1 busy, bit 2 reserved bits.
        // Offset 21h is load control: writing bit 0 starts a fresh load when idle.
        // Offset 22h holds the image index in bits 3 to 0.
        // Offsets 23h and 24h give the low and high byte of that image word.
        // Offset 25h shows the seven decoded settings below a zero top bit.
        // Offsets 26h to 29h give the two string addresses and lengths.
        // Other offsets read as zero and ignore writes, so software may probe
        // freely without disturbing the load.

        // Software writes. A commit in the same cycle overrides the wake
        // control bit, since the write is skipped while the state is ECWL_COMMIT.
        if (reg_req_in.wr)
        begin
            // Software may set or clear the enable; the next load replaces it.
            if (hit(reg_req_in, `ECWL_REG_WAKE_CTRL) && st.fsm != ECWL_COMMIT)
            begin
                next_st.cfg.wake_lan_mgmt_event =
                    reg_req_in.wdata[`ECWL_WAKE_WLME_POS];                   // RL5
            end
            // The image word follows two cycles after an index write: one for the
            // store's read register and one for the shadow copy here.
            if (hit(reg_req_in, `ECWL_REG_IMG_INDEX))
            begin
                next_st.img_index = reg_req_in.wdata[3:0];
            end
        end

        // Read data stand only in the cycle after the read strobe.
        // Every branch reads the state as it stood at the strobe edge, so a read
        // that meets a commit returns the old settings and the next read the new.
        // Later branches would override earlier ones, but the offsets are distinct,
        // so at most one of them matches.
        if (reg_req_in.rd)
        begin
            if (hit(reg_req_in, `ECWL_REG_WAKE_CTRL))
            begin
                next_st.rdata[`ECWL_WAKE_WLME_POS] = st.cfg.wake_lan_mgmt_event;
            end
            if (hit(reg_req_in, `ECWL_REG_LOAD_STAT))
            begin
                next_st.rdata[`ECWL_STAT_DONE]    = st.done;
                next_st.rdata[`ECWL_STAT_BUSY]    = (st.fsm != ECWL_DONE);
                next_st.rdata[`ECWL_STAT_RSV_ERR] = st.rsv_err;
            end
            if (hit(reg_req_in, `ECWL_REG_IMG_INDEX))
            begin
                next_st.rdata = {4'h0, st.img_index};
            end
            if (hit(reg_req_in, `ECWL_REG_IMG_LO))
            begin
                next_st.rdata = st.img_word[7:0];
            end
            if (hit(reg_req_in, `ECWL_REG_IMG_HI))
            begin
                next_st.rdata = st.img_word[15:8];
            end
            if (hit(reg_req_in, `ECWL_REG_CFG_VIEW))
            begin
                next_st.rdata = cfg_byte(st.cfg);
            end
            if (hit(reg_req_in, `ECWL_REG_VEND_ADDR))
            begin
                next_st.rdata = st.str.vendor_addr;
            end
            if (hit(reg_req_in, `ECWL_REG_VEND_LEN))
            begin
                next_st.rdata = st.str.vendor_len;
            end
            if (hit(reg_req_in, `ECWL_REG_PROD_ADDR))
            begin
                next_st.rdata = st.str.product_addr;
            end
            if (hit(reg_req_in, `ECWL_REG_PROD_LEN))
            begin
                next_st.rdata = st.str.product_len;
            end
        end
    end

    // Reset starts the load at once and holds the power-on defaults on every
    // setting except the software-writable management event enable until the commit. Crossover is the only setting that starts on.
    // Clearing the whole record first keeps the staging fields and flags free
    // of unknowns, so a status read during the first load is always clean.
    // The image store keeps no reset; it is only a window for software, and
    // each slot that a load fills is written before the status shows done.
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st                         <= '0;
            st.fsm                     <= ECWL_REQ;                          // RL13
            st.word_idx                <= `ECWL_WORD_CTRL;
            st.cfg.wake_magic_en       <= `ECWL_RST_MAGIC;
            st.cfg.wake_link_en        <= `ECWL_RST_LINK;
            st.cfg.led_mode            <= `ECWL_RST_LED;
            st.cfg.phy_enable          <= `ECWL_RST_PHY;
            st.cfg.fiber_mode          <= `ECWL_RST_FIBER;
            st.cfg.wake_lan_mgmt_event <= `ECWL_RST_WLME;
            st.cfg.mdix_en             <= `ECWL_RST_MDIX;
        end
        else
        begin
            st <= next_st;
        end
    end

    // All outputs are fields of the state register, so every pin leaves a
    // flip-flop and no setting can glitch while the words arrive.
    assign ee_req_out    = st.ee;
    assign reg_rdata_out = st.rdata;
    assign cfg_out       = st.cfg;
    assign str_out       = st.str;
    assign load_done_out = st.done;

endmodule : ecwl_loader

// ==== rtl/ecwl_consts.svh ====
`ifndef ECWL_CONSTS_SVH
`define ECWL_CONSTS_SVH

// EEPROM word indices of the configuration image.
`define ECWL_WORD_CTRL      8'h07
`define ECWL_WORD_STR1      8'h08
`define ECWL_WORD_STR2      8'h09

// Control word bit positions.
`define ECWL_BIT_MAGIC      4
`define ECWL_BIT_LINK       5
`define ECWL_BIT_LED        7
`define ECWL_BIT_PHY        8
`define ECWL_BIT_FIBER      9
`define ECWL_BIT_WLME       11
`define ECWL_BIT_RSV12      12
`define ECWL_BIT_RSV13      13
`define ECWL_BIT_MDIX       14
`define ECWL_BIT_RSV15      15

// Position of the management event enable inside the wake control register.
`define ECWL_WAKE_WLME_POS  7

// Settings in force before the first load has completed.
`define ECWL_RST_MAGIC      1'b0
`define ECWL_RST_LINK       1'b0
`define ECWL_RST_LED        1'b0
`define ECWL_RST_PHY        1'b0
`define ECWL_RST_FIBER      1'b0
`define ECWL_RST_WLME       1'b0
`define ECWL_RST_MDIX       1'b1

// Register port offsets.
`define ECWL_REG_WAKE_CTRL  8'h0F
`define ECWL_REG_LOAD_STAT  8'h20
`define ECWL_REG_LOAD_CTRL  8'h21
`define ECWL_REG_IMG_INDEX  8'h22
`define ECWL_REG_IMG_LO     8'h23
`define ECWL_REG_IMG_HI     8'h24
`define ECWL_REG_CFG_VIEW   8'h25
`define ECWL_REG_VEND_ADDR  8'h26
`define ECWL_REG_VEND_LEN   8'h27
`define ECWL_REG_PROD_ADDR  8'h28
`define ECWL_REG_PROD_LEN   8'h29

// Load status and control field positions.
`define ECWL_STAT_DONE      0
`define ECWL_STAT_BUSY      1
`define ECWL_STAT_RSV_ERR   2
`define ECWL_CTRL_RELOAD    0

`endif

// ==== rtl/ecwl_pkg.sv ====
package ecwl_pkg;

    // Decoded control word settings that steer the rest of the chip.
    typedef struct packed {
        logic wake_magic_en;
        logic wake_link_en;
        logic led_mode;
        logic phy_enable;
        logic fiber_mode;
        logic wake_lan_mgmt_event;
        logic mdix_en;
    } ecwl_cfg_t;

    // Description string locations inside the EEPROM.
    typedef struct packed {
        logic [7:0] vendor_addr;
        logic [7:0] vendor_len;
        logic [7:0] product_addr;
        logic [7:0] product_len;
    } ecwl_str_t;

    // Word read request towards the EEPROM access engine.
    typedef struct packed {
        logic       req;
        logic [7:0] addr;
    } ecwl_ee_req_t;

    // Software register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ecwl_reg_req_t;

    typedef enum logic [1:0] {
        ECWL_REQ    = 2'b00,
        ECWL_WAIT   = 2'b01,
        ECWL_COMMIT = 2'b10,
        ECWL_DONE   = 2'b11
    } ecwl_fsm_t;

    typedef struct packed {
        logic [15:0] rdata;
    } ecwl_mem_state_t;

endpackage : ecwl_pkg

// ==== rtl/ecwl_img_mem.sv ====
`timescale 1ns/100ps

// Copy of the loaded EEPROM words, kept so software can inspect the image.
module ecwl_img_mem
    import ecwl_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        we_in,
    input  wire logic [3:0]  waddr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic [3:0]  raddr_in,
    output logic      [15:0] rdata_out
);

    logic [15:0]     mem [16];
    ecwl_mem_state_t st;
    ecwl_mem_state_t next_st;

    // Storage has no reset; unread words are simply undefined until loaded.
    always_ff @(posedge ref_clk_in)
    begin
        if (we_in)
        begin
            mem[waddr_in] <= wdata_in;
        end
    end

    // Read data are registered so the port behaves like a synchronous RAM.
    always_comb
    begin
        next_st       = st;
        next_st.rdata = mem[raddr_in];
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_out = st.rdata;

endmodule : ecwl_img_mem

// ==== test/ecwl_loader_asserts.sv ====
`timescale 1ns/100ps

// Port-level checker; each property except a_cfg_default and a_done_sticky ties an output to the input that causes it.
module ecwl_loader_asserts
    import ecwl_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  ecwl_ee_req_t     ee_req_out,
    input  wire logic        ee_ack_in,
    input  ecwl_reg_req_t    reg_req_in,
    input  wire logic [7:0]  reg_rdata_out,
    input  ecwl_cfg_t        cfg_out,
    input  ecwl_str_t        str_out,
    input  wire logic        load_done_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // The answer to the last word closes the load; the commit follows one idle cycle later.
    sequence s_last_ack;
        ee_req_out.req && ee_ack_in && ee_req_out.addr == 8'h09;
    endsequence
    sequence s_commit;
        !ee_req_out.req ##1 load_done_out;
    endsequence

    a_cfg_default: assert property (!load_done_out |-> (cfg_out & 7'h7D) == 7'h01)
        else $error("settings left their defaults before the first load");
    a_req_hold: assert property (ee_req_out.req && !ee_ack_in |=> ee_req_out.req
        && $stable(ee_req_out.addr)) else $error("word request dropped before its answer");
    a_word_order: assert property (ee_req_out.req && ee_ack_in && ee_req_out.addr == 8'h07
        |=> !ee_req_out.req ##1 (ee_req_out.req && ee_req_out.addr == 8'h08))
        else $error("string word not fetched after the control word");
    a_load_commit: assert property (s_last_ack |=> s_commit)
        else $error("load not committed after the last word");
    a_done_sticky: assert property (load_done_out |=> load_done_out)
        else $error("load done fell");
    a_rdata_idle: assert property (!reg_req_in.rd |=> reg_rdata_out == 8'h00)
        else $error("read data without a read");
    a_cfg_view: assert property (reg_req_in.rd && reg_req_in.addr == 8'h25
        |=> reg_rdata_out == {1'b0, $past(cfg_out)}) else $error("settings view differs");
    a_wake_reg: assert property (reg_req_in.rd && reg_req_in.addr == 8'h0F
        |=> reg_rdata_out == {$past(cfg_out.wake_lan_mgmt_event), 7'h00})
        else $error("wake control bit differs from the setting");
    a_vendor_addr: assert property (reg_req_in.rd && reg_req_in.addr == 8'h26
        |=> reg_rdata_out == $past(str_out.vendor_addr)) else $error("vendor address differs");
endmodule : ecwl_loader_asserts

bind ecwl_loader ecwl_loader_asserts ecwl_loader_asserts_inst (.ref_clk_in, .rst_n_in,
    .ee_req_out, .ee_ack_in, .reg_req_in, .reg_rdata_out, .cfg_out, .str_out, .load_done_out);

// ==== test/ecwl_ee_model.sv ====
`timescale 1ns/100ps

// Stand-in for the configuration EEPROM; answers each word after delay_in idle cycles.
module ecwl_ee_model
    import ecwl_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  ecwl_ee_req_t     ee_req_in,
    input  wire logic [3:0]  delay_in,
    input  wire logic [47:0] image_in,
    output logic             ee_ack_out,
    output logic      [15:0] ee_data_out
);
    logic [3:0] wait_cnt;

    // Data toggles outside the answer cycle, so a sample taken late cannot pass by luck.
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ee_ack_out  <= 1'b0;
            ee_data_out <= 16'h0000;
            wait_cnt    <= 4'h0;
        end
        else if (ee_req_in.req && !ee_ack_out && wait_cnt >= delay_in)
        begin
            ee_ack_out  <= 1'b1;
            ee_data_out <= (ee_req_in.addr == 8'h07) ? image_in[15:0] :
                           (ee_req_in.addr == 8'h08) ? image_in[31:16] : image_in[47:32];
            wait_cnt    <= 4'h0;
        end
        else
        begin
            ee_ack_out  <= 1'b0;
            ee_data_out <= ~ee_data_out;
            wait_cnt    <= (ee_req_in.req && !ee_ack_out) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule : ecwl_ee_model

// ==== test/ecwl_loader_tb_top.sv ====
`timescale 1ns/100ps

module ecwl_loader_tb_top
    import ecwl_pkg::*;
;
    logic          ref_clk_in = 1'b0;
    logic          rst_n_in   = 1'b0;
    ecwl_ee_req_t  ee_req;
    logic          ee_ack;
    logic [15:0]   ee_data;
    ecwl_reg_req_t reg_req    = '0;
    logic [7:0]    reg_rdata;
    ecwl_cfg_t     cfg;
    ecwl_str_t     str;
    logic          load_done;
    logic [3:0]    delay      = 4'hF;
    logic [47:0]   image      = {16'h5A3C, 16'h2211, 16'h4290};
    logic [7:0]    rd_val;
    int            miscompares     = 0;
    int            samples_checked = 0;

    // Half period of 2 ns gives the 250 MHz clock.
    always #2 ref_clk_in = ~ref_clk_in;

    ecwl_loader ecwl_loader_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .ee_req_out(ee_req), .ee_ack_in(ee_ack), .ee_data_in(ee_data), .reg_req_in(reg_req),
        .reg_rdata_out(reg_rdata), .cfg_out(cfg), .str_out(str), .load_done_out(load_done));
    ecwl_ee_model ecwl_ee_model_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .ee_req_in(ee_req), .delay_in(delay), .image_in(image), .ee_ack_out(ee_ack),
        .ee_data_out(ee_data));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // One-cycle strobes launched just after an edge; read data is taken in the following cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_in);
        reg_req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_in);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_in);
        reg_req <= '0;
        #1 v = reg_rdata;
    endtask : rd

    // Polls the status until done is set and busy is clear, with a bounded count.
    task automatic wait_load;
        int n;
        for (n = 0; n < 60; n++)
        begin
            rd(8'h20, rd_val);
            if (rd_val[1] === 1'b0 && rd_val[0] === 1'b1)
                break;
        end
        if (n == 60)
        begin
            miscompares++;
            wrap_up();
        end
    endtask : wait_load

    // Compares every decoded field and its register copy with the loaded words.
    task automatic t_check_image;
        logic [31:0] s;
        logic [6:0]  c;
        s = {image[23:16], image[31:24], image[39:32], image[47:40]};
        c = {image[4], image[5], image[7], image[8], image[9], image[11], image[14]};
        chk(cfg, c);
        chk(str, s);
        rd(8'h0F, rd_val);
        chk(rd_val, {image[11], 7'h00});
        rd(8'h25, rd_val);
        chk(rd_val, {1'b0, c});
        for (int i = 0; i < 4; i++)
        begin
            rd(8'h26 + 8'(i), rd_val);
            chk(rd_val, s[31 - 8 * i -: 8]);
        end
    endtask : t_check_image

    task automatic t_defaults;
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk({load_done, cfg}, {1'b0, 7'h01});
        chk(str, 32'h0000_0000);
        chk({ee_req.req, ee_req.addr}, 9'h107);
        wait_load();
        t_check_image();
    endtask : t_defaults

    // Reload with new words; the model answers at once, then the old image must be replaced.
    task automatic t_reload(input logic [47:0] img, input logic [7:0] stat);
        image <= img;
        delay <= 4'h0;
        wr(8'h21, 8'h01);
        repeat (2) @(posedge ref_clk_in);
        rd(8'h20, rd_val);
        chk(rd_val, 8'h03);
        wait_load();
        t_check_image();
        rd(8'h20, rd_val);
        chk(rd_val & 8'h04, stat);
    endtask : t_reload

    // Software overwrites the management event enable; unmapped places stay silent.
    task automatic t_regs;
        wr(8'h0F, 8'h80);
        #1;
        chk(cfg.wake_lan_mgmt_event, 1'b1);
        rd(8'h0F, rd_val);
        chk(rd_val, 8'h80);
        wr(8'h30, 8'hFF);
        rd(8'h30, rd_val);
        chk(rd_val, 8'h00);
        rd(8'h21, rd_val);
        chk(rd_val, 8'h00);
        wr(8'h22, 8'h08);
        repeat (2) @(posedge ref_clk_in);
        rd(8'h22, rd_val);
        chk(rd_val, 8'h08);
        rd(8'h23, rd_val);
        chk(rd_val, image[23:16]);
        rd(8'h24, rd_val);
        chk(rd_val, image[31:24]);
    endtask : t_regs

    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        t_defaults();
        t_regs();
        t_reload({16'h0001, 16'h80FF, 16'h0920}, 8'h00);
        t_reload({16'hFFFF, 16'h0000, 16'hB000}, 8'h04);
        wrap_up();
    end
endmodule : ecwl_loader_tb_top
